// >>> hdl/edge_sync.sv
// Two-stage synchroniser plus rising and falling edge detect.
// Assumes the input may be asynchronous to aclk.
`default_nettype none
module edge_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Signal
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_ff;
  logic s1_ff;
  logic s2_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 1'b0;
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else if (ce) begin
      meta_ff <= din;
      s1_ff <= meta_ff;
      s2_ff <= s1_ff;
    end
  end
  assign level = s1_ff;
  assign rise = s1_ff & ~s2_ff;
  assign fall = ~s1_ff & s2_ff;
endmodule
`default_nettype wire

// >>> hdl/gated_timer.sv
// Gated 16-bit timer with prescaler and AXI4-Lite register slave.
// Assumes one 50 MHz clock; only external_clock_pin is sampled by a synchroniser, other pins are used directly.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none
module gated_timer #(
  parameter int INSTR_DIV = 4
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address, data and response
  input wire logic [gtimer_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [gtimer_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External pins and system
  input wire logic external_clock_pin,
  input wire logic gate_pin,
  input wire logic second_comparator,
  input wire logic sleep,
  input wire logic capture_event,
  input wire logic special_trigger,
  // Outputs to the system
  output logic crystal_osc_run,
  output logic crystal_pin0_direction,
  output logic crystal_pin1_direction,
  output logic counting_clock,
  output logic compare_event,
  output logic irq_request,
  output logic wake_request,
  output logic [15:0] wake_vector
);
  import gtimer_pkg::*;

  logic [CTL_W-1:0] ctl_ff;
  logic [15:0] count_ff;
  logic [PS_W-1:0] ps_ff;
  logic [IRQ_W:0] irq_ff;
  logic [15:0] capture_ff;
  logic [15:0] compare_ff;
  logic [1:0] icnt_ff;
  logic armed_ff;
  logic prev_on_ff;
  logic aw_ff, w_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic ext_level, ext_rise, ext_fall;
  logic [31:0] nxt_rdata;

  edge_sync u_ext (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .din(external_clock_pin),
    .level(ext_level),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  // Write channel capture; either order accepted
  wire wr_go = aw_ff & w_ff & ~s_axi_bvalid;
  wire wr_ctl = wr_go & (awaddr_ff == ADDR_CONTROL);
  wire wr_lo = wr_go & (awaddr_ff == ADDR_COUNT_LOW) & wstrb_ff[0];
  wire wr_hi = wr_go & (awaddr_ff == ADDR_COUNT_HIGH) & wstrb_ff[0];
  wire wr_irq = wr_go & (awaddr_ff == ADDR_IRQ) & wstrb_ff[0];
  wire wr_cmp = wr_go & (awaddr_ff == ADDR_COMPARE);
  wire wr_known = (awaddr_ff == ADDR_CONTROL) |
    (awaddr_ff == ADDR_COUNT_LOW) | (awaddr_ff == ADDR_COUNT_HIGH) |
    (awaddr_ff == ADDR_IRQ) | (awaddr_ff == ADDR_CAPTURE) |
    (awaddr_ff == ADDR_COMPARE) | (awaddr_ff == ADDR_PINS);
  wire wr_count = wr_lo | wr_hi;

  wire src_ext = ctl_ff[CTL_CS];
  wire instr_tick = (icnt_ff == 2'(INSTR_DIV - 1));
  // One edge path for both modes; the bit only widens sleep counting
  // With a single path a mode switch neither drops nor adds a tick
  wire ext_edge = ext_rise;
  wire gate_src = ctl_ff[CTL_GSS] ? second_comparator : gate_pin;
  // Invert bit set means count while gate is high
  wire gate_act = ctl_ff[CTL_GINV] ? gate_src : ~gate_src;
  wire gate_ok = ~ctl_ff[CTL_GE] | gate_act;
  // Sleep leaves only asynchronous external counting
  wire sleep_ok = ~sleep | (src_ext & ctl_ff[CTL_SYNCDIS]);
  wire run = ctl_ff[CTL_ON] & gate_ok & sleep_ok;
  // External edge counted only once a falling edge is seen
  wire raw_tick = src_ext ? (ext_edge & armed_ff) : instr_tick;
  wire [1:0] ps_sel = ctl_ff[CTL_PS_LO +: 2];
  // Prescale terminal value is 2**select minus one
  wire [PS_W-1:0] ps_last = PS_W'((4'h1 << ps_sel) - 4'h1);
  wire ps_wrap = (ps_ff == ps_last);
  wire inc = run & raw_tick & ps_wrap;
  wire wrap = inc & (count_ff == COUNT_MAX);
  wire osc_en = ctl_ff[CTL_OSCEN];
  wire irq_all = irq_ff[IRQ_FLAG] & irq_ff[IRQ_IE] & irq_ff[IRQ_PERIPHERAL_IRQ_ENABLE] &
    irq_ff[IRQ_GIE];
  // Wake needs counter on and two enables
  wire wake_all = irq_ff[IRQ_FLAG] & irq_ff[IRQ_IE] & irq_ff[IRQ_PERIPHERAL_IRQ_ENABLE] &
    ctl_ff[CTL_ON] & sleep;
  wire rd_go = s_axi_arvalid & s_axi_arready;

  // Free-running divider; software never resets its phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icnt_ff <= 2'h0;
    end else if (ce) begin
      icnt_ff <= instr_tick ? 2'h0 : icnt_ff + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_ff <= CONTROL_RESET;
      irq_ff <= '0;
      compare_ff <= COUNT_ZERO;
    end else if (ce) begin
      if (wr_ctl) begin
        ctl_ff <= wdata_ff[CTL_W-1:0];
      end
      if (wr_cmp) begin
        compare_ff <= wdata_ff[15:0];
      end
      // Flag sticky; set wins over a software clear
      if (wr_irq) begin
        irq_ff <= wdata_ff[IRQ_W:0] | {{IRQ_W{1'b0}}, wrap};
      end else if (wrap) begin
        irq_ff[IRQ_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= COUNT_ZERO;
      ps_ff <= PS_ZERO;
    end else if (ce) begin
      // A write replaces a coincident increment whole, never half of it
      // Write precedes special trigger
      if (wr_lo) begin
        count_ff[7:0] <= wdata_ff[7:0];
      end else if (wr_hi) begin
        count_ff[15:8] <= wdata_ff[7:0];
      end else if (special_trigger & ctl_ff[CTL_SPECIAL]) begin
        count_ff <= COUNT_ZERO;
      end else if (inc) begin
        count_ff <= count_ff + 16'h0001;
      end
      if (wr_count) begin
        ps_ff <= PS_ZERO;
      end else if (run & raw_tick) begin
        ps_ff <= ps_wrap ? PS_ZERO : ps_ff + PS_ONE;
      end
    end
  end

  // Arming: disarmed after reset, count write, or re-enable high
  // A pin already high at enable must fall first, or a false edge counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_ff <= 1'b0;
      prev_on_ff <= 1'b0;
    end else if (ce) begin
      prev_on_ff <= ctl_ff[CTL_ON];
      if (wr_count | (ctl_ff[CTL_ON] & ~prev_on_ff & ext_level)) begin
        armed_ff <= 1'b0;
      end else if (ext_fall) begin
        armed_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_ff <= COUNT_ZERO;
    end else if (ce & capture_event & ctl_ff[CTL_CAPEN]) begin
      capture_ff <= count_ff;
    end
  end

  // Write response; slave takes address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Readies drop while a transfer is pending, so one of each at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= ~aw_ff & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_ff & ~(s_axi_wvalid & s_axi_wready);
      s_axi_arready <= ~s_axi_rvalid & ~rd_go;
    end
  end

  // Reads see the clocked count, never a half-updated value
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (s_axi_araddr)
      ADDR_CONTROL: nxt_rdata[CTL_W-1:0] = ctl_ff;
      ADDR_COUNT_LOW: nxt_rdata[7:0] = count_ff[7:0];
      ADDR_COUNT_HIGH: nxt_rdata[7:0] = count_ff[15:8];
      ADDR_IRQ: nxt_rdata[IRQ_W:0] = irq_ff;
      ADDR_CAPTURE: nxt_rdata[15:0] = capture_ff;
      ADDR_COMPARE: nxt_rdata[15:0] = compare_ff;
      // Pins: with the oscillator on, data bits 1:0 read 0 and direction bits 3:2 read 1; off, bits 1:0 read ext_level and gate_pin
      ADDR_PINS: nxt_rdata[3:0] = osc_en ? 4'hC : {2'h0, ext_level,
        gate_pin};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  wire rd_known = (s_axi_araddr == ADDR_CONTROL) |
    (s_axi_araddr == ADDR_COUNT_LOW) | (s_axi_araddr == ADDR_COUNT_HIGH) |
    (s_axi_araddr == ADDR_IRQ) | (s_axi_araddr == ADDR_CAPTURE) |
    (s_axi_araddr == ADDR_COMPARE) | (s_axi_araddr == ADDR_PINS);

  // Data are latched at the address handshake and held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // System-side outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_osc_run <= 1'b0;
      crystal_pin0_direction <= 1'b0;
      crystal_pin1_direction <= 1'b0;
      counting_clock <= 1'b0;
      compare_event <= 1'b0;
      irq_request <= 1'b0;
      wake_request <= 1'b0;
      wake_vector <= COUNT_ZERO;
    end else if (ce) begin
      crystal_osc_run <= osc_en;
      crystal_pin0_direction <= osc_en;
      crystal_pin1_direction <= osc_en;
      // Counting clock pulse for comparator sync
      counting_clock <= run & raw_tick;
      // Match shows a cycle late, traded for a clean registered output
      // Compare match
      compare_event <= (count_ff == compare_ff);
      irq_request <= irq_all;
      wake_request <= wake_all;
      wake_vector <= irq_ff[IRQ_GIE] ? WAKE_VECTOR : COUNT_ZERO;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/gtimer_pkg.sv
// Constants for the gated 16-bit timer: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
`default_nettype none
package gtimer_pkg;
  localparam int AW = 5;
  // Register byte addresses
  localparam logic [AW-1:0] ADDR_CONTROL = 5'h00;
  localparam logic [AW-1:0] ADDR_COUNT_LOW = 5'h04;
  localparam logic [AW-1:0] ADDR_COUNT_HIGH = 5'h08;
  localparam logic [AW-1:0] ADDR_IRQ = 5'h0C;
  localparam logic [AW-1:0] ADDR_CAPTURE = 5'h10;
  localparam logic [AW-1:0] ADDR_COMPARE = 5'h14;
  localparam logic [AW-1:0] ADDR_PINS = 5'h18;
  // Control register fields
  localparam int CTL_ON = 0;
  localparam int CTL_CS = 1;
  localparam int CTL_SYNCDIS = 2;
  localparam int CTL_OSCEN = 3;
  localparam int CTL_PS_LO = 4;
  localparam int CTL_GE = 6;
  localparam int CTL_GINV = 7;
  localparam int CTL_GSS = 8;
  localparam int CTL_CAPEN = 9;
  localparam int CTL_SPECIAL = 10;
  localparam int CTL_W = 11;
  // Interrupt register fields
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_IE = 1;
  localparam int IRQ_PERIPHERAL_IRQ_ENABLE = 2;
  localparam int IRQ_GIE = 3;
  localparam int IRQ_W = 3;
  localparam logic [CTL_W-1:0] CONTROL_RESET = 11'h000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] WAKE_VECTOR = 16'h0004;
  // Prescaler: divide by 2**select, 1 to 8
  localparam int PS_W = 3;
  localparam logic [PS_W-1:0] PS_ZERO = 3'h0;
  localparam logic [PS_W-1:0] PS_ONE = 3'h1;
endpackage
`default_nettype wire

// >>> tb/gated_timer_chk.sv
// Port-level checker for the gated timer.
// Assumes it is bound to gated_timer and sees only its ports.
`default_nettype none
module gated_timer_chk #(
  parameter int INSTR_DIV = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // System side
  input wire logic sleep,
  input wire logic crystal_osc_run,
  input wire logic crystal_pin0_direction,
  input wire logic crystal_pin1_direction,
  input wire logic counting_clock,
  input wire logic irq_request,
  input wire logic wake_request,
  input wire logic [15:0] wake_vector
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_osc_pins: assert property (
    crystal_pin0_direction == crystal_osc_run &&
    crystal_pin1_direction == crystal_osc_run)
    else $error("crystal pins not forced with oscillator");
  a_tick_pulse: assert property (
    counting_clock && ce |=> !counting_clock)
    else $error("counting clock wider than one cycle");
  a_irq_vector: assert property (
    irq_request |-> wake_vector == 16'h0004)
    else $error("interrupt without global enable");
  a_vector_vals: assert property (
    wake_vector == 16'h0000 || wake_vector == 16'h0004)
    else $error("wake vector out of range");
  a_wake_sleep: assert property (
    $rose(wake_request) |-> $past(sleep))
    else $error("wake raised while awake");
  // Frozen state also covers the bus, so a stall never loses an answer
  a_ce_freeze: assert property (
    !ce |=> $stable({irq_request, wake_request, counting_clock,
                     crystal_osc_run, s_axi_bvalid, s_axi_rvalid}))
    else $error("state moved with clock enable low");
endmodule
bind gated_timer gated_timer_chk #(.INSTR_DIV(INSTR_DIV)) chk (
  .aclk, .aresetn, .ce, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sleep, .crystal_osc_run,
  .crystal_pin0_direction, .crystal_pin1_direction, .counting_clock,
  .irq_request, .wake_request, .wake_vector
);
`default_nettype wire

// >>> tb/gt_ext_clock.sv
// External clock source: bursts of n full pulses on the count pin.
// Assumes start is a one-cycle strobe; pin rests low between bursts.
`default_nettype none
module gt_ext_clock (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Burst request
  input wire logic start,
  input wire logic slow,
  input wire logic [7:0] n,
  // Pin side
  output logic pin,
  output logic busy
);
  logic [8:0] left_ff;
  logic [2:0] ph_ff;
  logic pin_ff;
  assign pin = pin_ff;
  assign busy = left_ff != 9'h000;
  // rising edges only inside a burst, each after a low phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_ff <= 9'h000;
      ph_ff <= 3'h0;
      pin_ff <= 1'b0;
    end else if (start) begin
      left_ff <= {n, 1'b0};
      ph_ff <= 3'h0;
    end else if (busy) begin
      ph_ff <= (ph_ff == (slow ? 3'h6 : 3'h2)) ? 3'h0 : ph_ff + 3'h1;
      if (ph_ff == (slow ? 3'h6 : 3'h2)) begin
        left_ff <= left_ff - 9'h001;
        pin_ff <= ~pin_ff;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_gated_timer.sv
// Self-checking bench for the gated timer through its register bus.
// Assumes gt_ext_clock drives the count pin; the checker is bound.
`default_nettype none
module test_gated_timer;
  timeunit 1ns;
  timeprecision 1ns;
  import gtimer_pkg::*;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, start, slow, busy;
  logic external_clock_pin, gate_pin, second_comparator, sleep, act;
  logic capture_event, special_trigger, crystal_osc_run, compare_event;
  logic crystal_pin0_direction, crystal_pin1_direction, counting_clock;
  logic irq_request, wake_request;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] wake_vector, v;
  logic [7:0] npulse;
  logic [33:0] q[$];
  int n_fail, n_checks, seed, cyc;
  gated_timer #(.INSTR_DIV(4)) dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .external_clock_pin, .gate_pin,
    .second_comparator, .sleep, .capture_event, .special_trigger,
    .crystal_osc_run, .crystal_pin0_direction, .crystal_pin1_direction,
    .counting_clock, .compare_event, .irq_request, .wake_request,
    .wake_vector
  );
  gt_ext_clock ext (
    .aclk, .aresetn, .start, .slow, .n(npulse), .pin(external_clock_pin),
    .busy
  );
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Whole run is a few thousand cycles; this only cuts a hang
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", {s_axi_bresp, 32'h0}, q.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", {s_axi_rresp, s_axi_rdata}, q.pop_front());
  end
  task automatic bus(input logic w, input logic [AW-1:0] a,
      input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic ta, tw, tr, dn;
    q.push_back({r, w ? 32'h0 : d});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      dn = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end while (!dn);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic run(input logic [31:0] c, input logic [15:0] s,
      input logic [7:0] k, input logic [15:0] e);
    // stop the counter before loading it
    bus(1, ADDR_CONTROL, 32'h0);
    bus(1, ADDR_COUNT_LOW, {24'h0, s[7:0]});
    bus(1, ADDR_COUNT_HIGH, {24'h0, s[15:8]});
    bus(1, ADDR_CONTROL, c);
    npulse <= k;
    slow <= 1'($random(seed));
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    @(negedge aclk);
    while (busy) @(negedge aclk);
    repeat (8) @(posedge aclk);
    bus(0, ADDR_COUNT_LOW, {24'h0, e[7:0]});
    bus(0, ADDR_COUNT_HIGH, {24'h0, e[15:8]});
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, gate_pin, second_comparator, sleep, start, slow} = '0;
    {capture_event, special_trigger, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, npulse, n_fail, n_checks, cyc} = '0;
    ce = 1'b1;
    seed = 73840;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, ADDR_CONTROL, 32'h0);
    bus(0, ADDR_IRQ, 32'h0);
    bus(0, 5'h1C, 32'h0, RESP_SLVERR);
    bus(1, 5'h1C, 32'h1, RESP_SLVERR);
    // ratios; first rise after a load is not counted
    for (int p = 0; p < 4; p++) begin
      v = 16'($random(seed));
      run(32'h3 | (32'(p) << 4), v, 8'((5 << p) + 1), v + 16'h5);
    end
    for (int i = 0; i < 8; i++) begin
      gate_pin <= 1'($random(seed));
      second_comparator <= 1'($random(seed));
      @(posedge aclk);
      act = !i[0] || ((i[2] ? second_comparator : gate_pin) == i[1]);
      run(32'h3 | (32'(i) << 6), 16'h0, 8'h3, act ? 16'h2 : 16'h0);
    end
    // oscillator takes over the crystal pins
    bus(1, ADDR_CONTROL, 32'h8);
    // let the oscillator settle before the counter is started
    repeat (16) @(posedge aclk);
    bus(1, ADDR_CONTROL, 32'h9);
    bus(0, ADDR_PINS, 32'hC);
    chk("osc", {33'h0, crystal_osc_run & crystal_pin0_direction &
      crystal_pin1_direction}, 34'h1);
    bus(1, ADDR_CONTROL, 32'h0);
    bus(0, ADDR_PINS, {31'h0, gate_pin});
    // only unsynchronised counting runs in sleep
    bus(1, ADDR_IRQ, 32'hE);
    sleep <= 1'b1;
    run(32'h3, 16'hFFFF, 8'h3, 16'hFFFF);
    run(32'h7, 16'hFFFF, 8'h3, 16'h0001);
    @(negedge aclk);
    chk("wake", {wake_request, irq_request, wake_vector},
      {18'h3, WAKE_VECTOR});
    bus(0, ADDR_IRQ, 32'hF);
    bus(1, ADDR_IRQ, 32'h0);
    sleep <= 1'b0;
    bus(0, ADDR_IRQ, 32'h0);
    @(negedge aclk);
    chk("irq", {32'h0, wake_request, irq_request}, 34'h0);
    // capture and compare on a stopped, synchronised count
    run(32'h600, 16'h1234, 8'h0, 16'h1234);
    capture_event <= 1'b1;
    @(posedge aclk);
    capture_event <= 1'b0;
    bus(1, ADDR_COMPARE, 32'h1234);
    bus(0, ADDR_CAPTURE, 32'h1234);
    @(negedge aclk);
    chk("compare", {33'h0, compare_event}, 34'h1);
    // trigger clears the count and leaves the flag alone
    @(posedge aclk);
    special_trigger <= 1'b1;
    @(posedge aclk);
    special_trigger <= 1'b0;
    bus(0, ADDR_COUNT_LOW, 32'h0);
    bus(0, ADDR_COUNT_HIGH, 32'h0);
    bus(0, ADDR_IRQ, 32'h0);
    ce <= 1'b0;
    repeat (4) @(posedge aclk);
    ce <= 1'b1;
    bus(0, ADDR_CONTROL, 32'h600);
    // internal source: 44 enabled clocks give 11 ticks, 5 at 1:2
    bus(1, ADDR_CONTROL, 32'h11);
    repeat (40) @(posedge aclk);
    bus(1, ADDR_CONTROL, 32'h400);
    bus(0, ADDR_COUNT_LOW, 32'h5);
    // trigger held over the write edge; the write must survive
    fork
      bus(1, ADDR_COUNT_LOW, 32'hA5);
      begin
        @(posedge aclk);
        special_trigger <= 1'b1;
        repeat (2) @(posedge aclk);
        special_trigger <= 1'b0;
      end
    join
    bus(0, ADDR_COUNT_LOW, 32'hA5);
    // the write cleared a half-full prescaler: one tick, no increment
    bus(1, ADDR_CONTROL, 32'h11);
    bus(1, ADDR_CONTROL, 32'h400);
    bus(0, ADDR_COUNT_LOW, 32'hA5);
    give_verdict();
  end
endmodule
`default_nettype wire
